/* File: hw/dtd_regs.svh */
// Purpose: named constants of the tone dialer and its serial port
// Assumes: included by bare name from the synchroniser, tone generator, dialer and bench files
// Notes: divisor pairs are counts of 500 kHz ticks
`ifndef DTD_REGS_SVH
`define DTD_REGS_SVH
// timing
`define DTD_CLK_PERIOD_NS 50
`define DTD_OSC_PERIOD_NS 2000
`define DTD_OSC_DIV (`DTD_OSC_PERIOD_NS / `DTD_CLK_PERIOD_NS)
// register byte offsets
`define DTD_ADR_CTRL 4'h0
`define DTD_ADR_STATUS 4'h4
`define DTD_ADR_SHIFT 4'h8
// control fields and reset value
`define DTD_CTRL_DIR 0
`define DTD_CTRL_INH 1
`define DTD_CTRL_MIC 2
`define DTD_CTRL_RST 3'h2
// status fields
`define DTD_ST_VALID 0
`define DTD_ST_MUTE 1
`define DTD_ST_ROW 2
`define DTD_ST_COL 3
`define DTD_ST_LOADED 4
`define DTD_ST_MIC 5
`define DTD_ST_CODE 11:8
// interval encoder and peak intervals
`define DTD_ALT_IDX_A 4'h0
`define DTD_ALT_IDX_B 4'h8
`define DTD_LEVEL_MID 4'h8
// serial framing
`define DTD_SER_LAST_BIT 3'h3
`define DTD_SER_SHIFT_END 3'h4
`define DTD_SER_RELOAD 3'h5
// divisor pairs: normal, alternate (rows 697..941, cols 1209..1633)
`define DTD_DIV_R0 {6'h2D, 6'h2C}
`define DTD_DIV_R1 {6'h29, 6'h26}
`define DTD_DIV_R2 {6'h25, 6'h22}
`define DTD_DIV_R3 {6'h21, 6'h23}
`define DTD_DIV_C0 {6'h1A, 6'h19}
`define DTD_DIV_C1 {6'h17, 6'h1A}
`define DTD_DIV_C2 {6'h15, 6'h16}
`define DTD_DIV_C3 {6'h13, 6'h14}
`endif

/* File: hw/dtd_pkg.sv */
// Purpose: shared types of the tone dialer
// Assumes: constants live in dtd_regs.svh
// Notes: the tone generator and the synchroniser keep their state in these structs
package dtd_pkg;
	typedef logic [5:0] dtd_div_t;
	typedef logic [3:0] dtd_level_t;
	typedef struct packed {
		dtd_div_t div_cnt;
		logic [3:0] interval;
		dtd_level_t level;
	} dtd_gen_state_t;
	typedef struct packed {
		logic [9:0] s1;
		logic [9:0] s2;
		logic [9:0] s3;
		logic [9:0] lvl;
	} dtd_sync_state_t;
endpackage

/* File: hw/dtd_tone_if.sv */
// Purpose: control and level path between dialer and one tone generator
// Assumes: one instance per tone channel
// Notes: divisors follow the latched key code and can change while enable is high
`timescale 1ns/10ps
interface dtd_tone_if;
	logic tick;
	logic en;
	dtd_pkg::dtd_div_t div_main;
	dtd_pkg::dtd_div_t div_alt;
	dtd_pkg::dtd_level_t level;
	modport ctl(output tick, en, div_main, div_alt, input level);
	modport gen(input tick, en, div_main, div_alt, output level);
endinterface

/* File: hw/dtd_sync3.sv */
// Purpose: three-stage synchroniser for keypad and serial pins
// Assumes: ten pins, asynchronous to I_CLK
// Notes: a level is taken only when stages two and three agree
`timescale 1ns/10ps
`include "dtd_regs.svh"
module dtd_sync3 (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [9:0] i_async,
	output wire logic [9:0] o_level
);
	import dtd_pkg::*;
	dtd_sync_state_t s_r;
	dtd_sync_state_t s_nxt;

	// shift chain, filtered level follows agreeing stages
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = i_async;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		s_nxt.lvl = (~(s_r.s2 ^ s_r.s3) & s_r.s3) |
			((s_r.s2 ^ s_r.s3) & s_r.lvl);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_level = s_r.lvl;
endmodule

/* File: hw/dtd_tone_gen.sv */
// Purpose: one tone generator: programmable divider and interval counter
// Assumes: tick is one clock wide at 500 kHz
// Notes: level is a 16-step stair approximation, peaks at steps 0 and 8
`timescale 1ns/10ps
`include "dtd_regs.svh"
module dtd_tone_gen (
	input wire logic i_clk,
	input wire logic i_rst_n,
	dtd_tone_if.gen tone
);
	import dtd_pkg::*;
	dtd_gen_state_t s_r;
	dtd_gen_state_t s_nxt;
	logic [3:0] next_int;
	dtd_div_t next_div;

	// stair encoder of the interval count
	function automatic dtd_level_t enc(input logic [3:0] idx);
		unique case (idx)
			4'h0: enc = 4'hF;
			4'h1, 4'hF: enc = 4'hE;
			4'h2, 4'hE: enc = 4'hD;
			4'h3, 4'hD: enc = 4'hB;
			4'h4, 4'hC: enc = 4'h8;
			4'h5, 4'hB: enc = 4'h5;
			4'h6, 4'hA: enc = 4'h3;
			4'h7, 4'h9: enc = 4'h2;
			4'h8: enc = 4'h1;
		endcase
	endfunction

	// divider reload and interval stepping
	always_comb begin
		s_nxt = s_r;
		next_int = (s_r.div_cnt == '0) ? s_r.interval : s_r.interval + 4'h1;
		next_div = (next_int == `DTD_ALT_IDX_A || next_int == `DTD_ALT_IDX_B)
			? tone.div_alt : tone.div_main;
		if (!tone.en) begin
			s_nxt.div_cnt = '0;
			s_nxt.interval = '0;
			s_nxt.level = `DTD_LEVEL_MID;
		end else begin
			if (tone.tick) begin
				if (s_r.div_cnt <= 6'h01) begin
					s_nxt.div_cnt = next_div;
					s_nxt.interval = next_int;
				end else begin
					s_nxt.div_cnt = s_r.div_cnt - 6'h01;
				end
			end
			s_nxt.level = enc(s_r.interval);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '{div_cnt: '0, interval: '0, level: `DTD_LEVEL_MID};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tone.level = s_r.level;
endmodule

/* File: hw/dtd_dialer.sv */
// Purpose: digital tone dialer with keypad decode and serial digit port
// Assumes: I_CLK 20 MHz; serial clock and keypad are asynchronous pins
// Notes: registers reached over classic Wishbone, one aligned word each
// Overview of operation
// - in manual mode two keypad lines shorted start row and column tones
// - tone generation also raises the internal speech mute
// - 4-bit interval counter steps 16 intervals, encoder gives level
// - divider on 500 kHz reloads each interval; terminal advances it
// - first and ninth intervals use alternate divisor, 44 versus 45 for the 697 Hz row
// - divisor pairs keep every tone within 0.16 percent
// - each key maps to a 4-bit code selecting both divisors
// - direction select sets serial flow out of or into the device
// - manual mode sends key code to tones and the shift register
// - shift register moves data on falling serial clock edges
// - manual mode: six clocks read four bits then reload
// - automatic mode: no load phase, four clocks shift one digit in
// - tones in automatic mode only while inhibit is low
// - several keys detected; in manual mode two in one line give single tone
// - key valid only while exactly one key is pressed
// - mute status shows tone generator on and speech muted
// - microphone muted during tones or by mute control
`timescale 1ns/10ps
`include "dtd_regs.svh"
module dtd_dialer (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [3:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output wire logic [31:0] O_WB_DAT,
	output wire logic O_WB_ACK,
	input wire logic [3:0] I_KEY_ROW,
	input wire logic [3:0] I_KEY_COL,
	input wire logic I_SER_CLK,
	input wire logic I_SER_DATA,
	output wire logic O_SER_DATA,
	output wire logic O_SER_DATA_OE,
	output wire dtd_pkg::dtd_level_t O_ROW_LEVEL,
	output wire dtd_pkg::dtd_level_t O_COL_LEVEL,
	output wire logic O_SINGLE_KEY_VALID,
	output wire logic O_DIALER_MUTE_STATUS,
	output wire logic O_MIC_MUTE
);
	import dtd_pkg::*;

	// whole state of the dialer top
	typedef struct packed {
		logic dir;
		logic inh;
		logic mic_ctl;
		logic ack;
		logic [31:0] rdata;
		logic [5:0] presc;
		logic tick;
		logic sclk_prev;
		logic [2:0] ser_cnt;
		logic [3:0] shreg;
		logic loaded;
		logic sdo;
		logic sdo_oe;
		logic key_valid;
		logic row_on;
		logic col_on;
		logic [3:0] code;
		logic mute;
		logic mic_mute;
		dtd_level_t row_level;
		dtd_level_t col_level;
	} dtd_top_state_t;

	dtd_top_state_t s_r;
	dtd_top_state_t s_nxt;
	logic [9:0] pin_lvl;
	logic [3:0] row_lvl;
	logic [3:0] col_lvl;
	logic sclk_lvl;
	logic sdin_lvl;
	logic one_row;
	logic one_col;
	logic [1:0] row_idx;
	logic [1:0] col_idx;
	logic [3:0] key_code;
	logic sclk_fall;
	logic req;
	logic row_want;
	logic col_want;
	logic [3:0] tone_code;
	logic [11:0] row_pair;
	logic [11:0] col_pair;
	dtd_level_t gen_level [2];

	// exactly one bit of a four-line group set
	function automatic logic is_one(input logic [3:0] v);
		is_one = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
	endfunction

	// index of the lowest set line
	function automatic logic [1:0] idx_of(input logic [3:0] v);
		if (v[0]) begin
			idx_of = 2'h0;
		end else if (v[1]) begin
			idx_of = 2'h1;
		end else if (v[2]) begin
			idx_of = 2'h2;
		end else begin
			idx_of = 2'h3;
		end
	endfunction

	// keypad and serial pins through the synchroniser
	dtd_sync3 u_sync (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_async({I_SER_DATA, I_SER_CLK, I_KEY_COL, I_KEY_ROW}),
		.o_level(pin_lvl)
	);

	assign row_lvl = pin_lvl[3:0];
	assign col_lvl = pin_lvl[7:4];
	assign sclk_lvl = pin_lvl[8];
	assign sdin_lvl = pin_lvl[9];

	// keypad decode
	always_comb begin
		one_row = is_one(row_lvl);
		one_col = is_one(col_lvl);
		row_idx = idx_of(row_lvl);
		col_idx = idx_of(col_lvl);
		key_code = {row_idx, col_idx};
	end

	// tone requests for manual and automatic dialing
	always_comb begin
		if (s_r.dir) begin
			row_want = s_r.loaded && !s_r.inh;
			col_want = s_r.loaded && !s_r.inh;
			tone_code = s_r.shreg;
		end else begin
			row_want = one_row && (col_lvl != 4'h0);
			col_want = one_col && (row_lvl != 4'h0);
			tone_code = key_code;
		end
	end

	always_comb begin
		unique case (s_r.code[3:2])
			2'h0: row_pair = `DTD_DIV_R0;
			2'h1: row_pair = `DTD_DIV_R1;
			2'h2: row_pair = `DTD_DIV_R2;
			2'h3: row_pair = `DTD_DIV_R3;
		endcase
		unique case (s_r.code[1:0])
			2'h0: col_pair = `DTD_DIV_C0;
			2'h1: col_pair = `DTD_DIV_C1;
			2'h2: col_pair = `DTD_DIV_C2;
			2'h3: col_pair = `DTD_DIV_C3;
		endcase
	end

	// row and column tone channels
	dtd_tone_if tone_ch[2] ();

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_tone
			assign tone_ch[ch].tick = s_r.tick;
			assign tone_ch[ch].en = (ch == 0) ? s_r.row_on : s_r.col_on;
			assign tone_ch[ch].div_main = (ch == 0) ?
				row_pair[11:6] : col_pair[11:6];
			assign tone_ch[ch].div_alt = (ch == 0) ?
				row_pair[5:0] : col_pair[5:0];
			assign gen_level[ch] = tone_ch[ch].level;
			dtd_tone_gen u_gen (
				.i_clk(I_CLK),
				.i_rst_n(I_RST_N),
				.tone(tone_ch[ch].gen)
			);
		end
	endgenerate

	assign sclk_fall = s_r.sclk_prev && !sclk_lvl;
	assign req = I_WB_CYC && I_WB_STB;

	// next state of the whole top
	always_comb begin
		s_nxt = s_r;
		// 500 kHz tick from the system clock
		if (s_r.presc == 6'(`DTD_OSC_DIV - 1)) begin
			s_nxt.presc = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.presc = s_r.presc + 6'h01;
			s_nxt.tick = 1'b0;
		end

		// status of keypad and tones
		// single key
		s_nxt.key_valid = one_row && one_col;
		s_nxt.row_on = row_want;
		s_nxt.col_on = col_want;
		if (row_want || col_want) begin
			s_nxt.code = tone_code;
		end
		s_nxt.mute = row_want || col_want;
		s_nxt.mic_mute = row_want || col_want || s_r.mic_ctl;
		s_nxt.row_level = gen_level[0];
		s_nxt.col_level = gen_level[1];

		// serial digit port
		s_nxt.sclk_prev = sclk_lvl;
		s_nxt.sdo_oe = !s_r.dir;
		if (!s_r.dir) begin
			s_nxt.loaded = 1'b0;
			if (s_r.ser_cnt == 3'h0 && one_row && one_col) begin
				s_nxt.shreg = key_code;
			end
			if (sclk_fall) begin
				if (s_r.ser_cnt == `DTD_SER_RELOAD) begin
					s_nxt.ser_cnt = 3'h0;
				end else begin
					s_nxt.ser_cnt = s_r.ser_cnt + 3'h1;
				end
				if (s_r.ser_cnt != 3'h0 &&
					s_r.ser_cnt <= `DTD_SER_SHIFT_END) begin
					s_nxt.shreg = {s_r.shreg[2:0], 1'b0};
				end
			end
			s_nxt.sdo = s_nxt.shreg[3];
		end else begin
			s_nxt.sdo = 1'b0;
			if (sclk_fall) begin
				s_nxt.shreg = {s_r.shreg[2:0], sdin_lvl};
				if (s_r.ser_cnt == `DTD_SER_LAST_BIT) begin
					s_nxt.ser_cnt = 3'h0;
					s_nxt.loaded = 1'b1;
				end else begin
					s_nxt.ser_cnt = s_r.ser_cnt + 3'h1;
					s_nxt.loaded = 1'b0;
				end
			end
		end
		// a direction change restarts the framing
		if (req && I_WB_WE && s_r.ack && I_WB_SEL[0] &&
			I_WB_ADR == `DTD_ADR_CTRL &&
			I_WB_DAT[`DTD_CTRL_DIR] != s_r.dir) begin
			s_nxt.ser_cnt = 3'h0;
			s_nxt.loaded = 1'b0;
		end

		// bus slave: ack one cycle after the request, then drop
		s_nxt.ack = req && !s_r.ack;
		if (req && !s_r.ack) begin
			s_nxt.rdata = '0;
			unique case (I_WB_ADR)
				`DTD_ADR_CTRL: begin
					s_nxt.rdata[`DTD_CTRL_DIR] = s_r.dir;
					s_nxt.rdata[`DTD_CTRL_INH] = s_r.inh;
					s_nxt.rdata[`DTD_CTRL_MIC] = s_r.mic_ctl;
				end
				`DTD_ADR_STATUS: begin
					s_nxt.rdata[`DTD_ST_VALID] = s_r.key_valid;
					s_nxt.rdata[`DTD_ST_MUTE] = s_r.mute;
					s_nxt.rdata[`DTD_ST_ROW] = s_r.row_on;
					s_nxt.rdata[`DTD_ST_COL] = s_r.col_on;
					s_nxt.rdata[`DTD_ST_LOADED] = s_r.loaded;
					s_nxt.rdata[`DTD_ST_MIC] = s_r.mic_mute;
					s_nxt.rdata[`DTD_ST_CODE] = s_r.code;
				end
				`DTD_ADR_SHIFT: begin
					s_nxt.rdata[3:0] = s_r.shreg;
				end
				default: begin
					s_nxt.rdata = '0;
				end
			endcase
		end
		// write takes effect on the acknowledging edge
		if (req && I_WB_WE && s_r.ack && I_WB_SEL[0] &&
			I_WB_ADR == `DTD_ADR_CTRL) begin
			s_nxt.dir = I_WB_DAT[`DTD_CTRL_DIR];
			s_nxt.inh = I_WB_DAT[`DTD_CTRL_INH];
			s_nxt.mic_ctl = I_WB_DAT[`DTD_CTRL_MIC];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			s_r <= '0;
			s_r.dir <= 1'(`DTD_CTRL_RST >> `DTD_CTRL_DIR);
			s_r.inh <= 1'b1;
			s_r.row_level <= `DTD_LEVEL_MID;
			s_r.col_level <= `DTD_LEVEL_MID;
			s_r.sdo_oe <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state flops
	assign O_WB_DAT = s_r.rdata;
	assign O_WB_ACK = s_r.ack;
	assign O_SER_DATA = s_r.sdo;
	assign O_SER_DATA_OE = s_r.sdo_oe;
	assign O_ROW_LEVEL = s_r.row_level;
	assign O_COL_LEVEL = s_r.col_level;
	assign O_SINGLE_KEY_VALID = s_r.key_valid;
	assign O_DIALER_MUTE_STATUS = s_r.mute;
	assign O_MIC_MUTE = s_r.mic_mute;
endmodule

/* File: test/dtd_dialer_props.sv */
// Purpose: port checks of the tone dialer
// Assumes: one clock domain, bound to the top module
// Notes: tone interval lengths are measured in the bench
`timescale 1ns/10ps
module dtd_dialer_props (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic O_WB_ACK,
	input wire logic [3:0] I_KEY_ROW,
	input wire logic [3:0] I_KEY_COL,
	input wire dtd_pkg::dtd_level_t O_ROW_LEVEL,
	input wire dtd_pkg::dtd_level_t O_COL_LEVEL,
	input wire logic O_SINGLE_KEY_VALID,
	input wire logic O_DIALER_MUTE_STATUS,
	input wire logic O_MIC_MUTE
);
	import dtd_pkg::*;
	logic [11:0] hold_cnt;
	logic [3:0] row_prv;
	logic one_key;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// exactly one row line and one column line
	assign one_key = $onehot(I_KEY_ROW) && $onehot(I_KEY_COL);
	// cycles the row level has stood still during a tone
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			hold_cnt <= 12'h000;
			row_prv <= 4'h8;
		end else begin
			row_prv <= O_ROW_LEVEL;
			if (O_DIALER_MUTE_STATUS && O_ROW_LEVEL == row_prv) begin
				hold_cnt <= hold_cnt + 12'h001;
			end else begin
				hold_cnt <= 12'h000;
			end
		end
	end
	a_ack_next: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
		else $error("no ack after request");
	a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack longer than one cycle");
	a_reset_quiet: assert property ($rose(I_RST_N) |->
		O_ROW_LEVEL == 4'h8 && O_COL_LEVEL == 4'h8 && !O_SINGLE_KEY_VALID
		&& !O_DIALER_MUTE_STATUS && !O_MIC_MUTE)
		else $error("outputs not clear after reset");
	a_valid_key: assert property (one_key [*8] |-> O_SINGLE_KEY_VALID)
		else $error("single key not flagged");
	a_multi_invalid: assert property ((!one_key) [*8] |->
		!O_SINGLE_KEY_VALID)
		else $error("key valid without a single key");
	a_key_tone: assert property (one_key [*8] |-> O_DIALER_MUTE_STATUS)
		else $error("key press gives no tone");
	a_tone_mic: assert property (O_DIALER_MUTE_STATUS |-> O_MIC_MUTE)
		else $error("microphone live during tone");
	a_idle_mid: assert property ((!O_DIALER_MUTE_STATUS) [*4] |->
		O_ROW_LEVEL == 4'h8 && O_COL_LEVEL == 4'h8)
		else $error("tone level without mute");
	a_row_steps: assert property (hold_cnt < 12'hE74)
		else $error("row level stuck during tone");
	c_valid: cover property (O_SINGLE_KEY_VALID);
	c_peak: cover property (O_ROW_LEVEL == 4'hF);
	c_mic: cover property (O_MIC_MUTE && !O_DIALER_MUTE_STATUS);
endmodule
bind dtd_dialer dtd_dialer_props u_props (
	.I_CLK, .I_RST_N, .I_WB_CYC, .I_WB_STB, .O_WB_ACK, .I_KEY_ROW,
	.I_KEY_COL, .O_ROW_LEVEL, .O_COL_LEVEL, .O_SINGLE_KEY_VALID,
	.O_DIALER_MUTE_STATUS, .O_MIC_MUTE
);

/* File: test/dtd_mpu_model.sv */
// Purpose: processor side of the serial digit port
// Assumes: serial clock idles high; a clock is a fall then a rise
// Notes: the data pin is released outside writes
`timescale 1ns/10ps
module dtd_mpu_model (
	input wire logic i_clk,
	input wire logic i_pin,
	output logic o_ser_clk,
	output logic o_ser_dat,
	output logic o_drive,
	output logic [3:0] o_word,
	output logic o_word_stb
);
	localparam int HALF = 8; // half serial period in system clocks
	initial begin
		o_ser_clk = 1'b1;
		o_ser_dat = 1'b0;
		o_drive = 1'b0;
		o_word = 4'h0;
		o_word_stb = 1'b0;
	end
	task automatic pulse();
		o_ser_clk <= 1'b0;
		repeat (HALF) @(posedge i_clk);
		o_ser_clk <= 1'b1;
		repeat (HALF) @(posedge i_clk);
	endtask
	// six clocks, bits taken after the first four rises
	task automatic read_word();
		logic [3:0] w;
		for (int k = 0; k < 6; k++) begin
			pulse();
			if (k < 4) w[3 - k] = i_pin;
		end
		o_word <= w;
		o_word_stb <= 1'b1;
		@(posedge i_clk);
		o_word_stb <= 1'b0;
	endtask
	// four clocks, msb first, bit set before each fall
	task automatic write_word(input logic [3:0] d);
		o_drive <= 1'b1;
		for (int k = 3; k >= 0; k--) begin
			o_ser_dat <= d[k];
			repeat (HALF) @(posedge i_clk);
			pulse();
		end
		o_drive <= 1'b0;
	endtask
endmodule

/* File: test/tb.sv */
// Purpose: self-checking bench of the tone dialer
// Assumes: 20 MHz clock; keypad and serial pins driven here
// Notes: results are compared in order against queued expectations
`timescale 1ns/10ps
`include "dtd_regs.svh"
module tb;
	import dtd_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0, row = 4'h0, col = 4'h0, w_word;
	logic [31:0] wdat = 32'h0, rdat, rnd = 32'hC133;
	logic ack, sdo, oe, kv, mute, mic, ser_clk, mpu_dat, mpu_oe, pin, w_stb;
	logic idle_tgl = 1'b0;
	dtd_level_t row_lv, col_lv;
	string exp_n[$];
	logic [31:0] exp_v[$], exp_m[$];
	int n_fail = 0, checked = 0;
	event meas_go, meas_done;
	dtd_dialer DUT (
		.I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
		.O_WB_DAT(rdat), .O_WB_ACK(ack), .I_KEY_ROW(row), .I_KEY_COL(col),
		.I_SER_CLK(ser_clk), .I_SER_DATA(pin), .O_SER_DATA(sdo),
		.O_SER_DATA_OE(oe), .O_ROW_LEVEL(row_lv), .O_COL_LEVEL(col_lv),
		.O_SINGLE_KEY_VALID(kv), .O_DIALER_MUTE_STATUS(mute),
		.O_MIC_MUTE(mic)
	);
	dtd_mpu_model u_mpu (
		.i_clk(clk), .i_pin(pin), .o_ser_clk(ser_clk), .o_ser_dat(mpu_dat),
		.o_drive(mpu_oe), .o_word(w_word), .o_word_stb(w_stb)
	);
	// data pin: device, processor, or a pattern while floating
	assign pin = oe ? sdo : (mpu_oe ? mpu_dat : idle_tgl);
	always @(posedge clk) idle_tgl <= ~idle_tgl;
	initial begin
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic push(input string n, input logic [31:0] v, m);
		exp_n.push_back(n);
		exp_v.push_back(v);
		exp_m.push_back(m);
	endtask
	task automatic got(input logic [31:0] s);
		string n;
		logic [31:0] v, m;
		checked++;
		n = "none";
		v = 'x;
		m = '1;
		if (exp_v.size() > 0) begin
			n = exp_n.pop_front();
			v = exp_v.pop_front();
			m = exp_m.pop_front();
		end
		if ((s & m) !== (v & m)) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, v, s);
		end
	endtask
	// one classic bus cycle, held until ack
	task automatic wb(input logic w, input logic [3:0] a, s,
		input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] v, m);
		push("read", v, m);
		wb(1'b0, a, 4'hF, 32'h0);
	endtask
	task automatic key(input logic [3:0] r, c);
		row <= r;
		col <= c;
		repeat (12) @(posedge clk);
	endtask
	// results as they appear at the outputs
	always @(posedge clk) begin
		if (ack === 1'b1 && !we) got(rdat);
		if (w_stb === 1'b1) got({28'h0, w_word});
	end
	// length of the trough run and of the run after it
	task automatic runs(input logic c);
		int n;
		dtd_level_t v;
		while ((c ? col_lv : row_lv) === 4'h1) @(posedge clk);
		while ((c ? col_lv : row_lv) !== 4'h1) @(posedge clk);
		for (int k = 0; k < 2; k++) begin
			v = c ? col_lv : row_lv;
			n = 0;
			while ((c ? col_lv : row_lv) === v) begin
				n++;
				@(posedge clk);
			end
			got(32'(n));
		end
	endtask
	initial begin
		@(meas_go);
		runs(1'b0);
		runs(1'b1);
		-> meas_done;
	end
	task automatic give_verdict();
		n_fail += exp_v.size();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// reset values, refused writes and an unmapped place
		rd(`DTD_ADR_CTRL, 32'h2, '1);
		rd(`DTD_ADR_SHIFT, 32'h0, '1);
		wb(1'b1, `DTD_ADR_STATUS, 4'hF, 32'hFF);
		rd(`DTD_ADR_STATUS, 32'h0, '1);
		rd(4'hC, 32'h0, '1);
		wb(1'b1, `DTD_ADR_CTRL, 4'hE, 32'h6);
		rd(`DTD_ADR_CTRL, 32'h2, '1);
		wb(1'b1, `DTD_ADR_CTRL, 4'hF, 32'h6);
		rd(`DTD_ADR_STATUS, 32'h20, 32'h23);
		wb(1'b1, `DTD_ADR_CTRL, 4'hF, 32'h2);
		// random single keys: status, register and two link reads
		repeat (3) begin
			rnd = lfsr(rnd);
			key(4'h1 << rnd[3:2], 4'h1 << rnd[1:0]);
			rd(`DTD_ADR_STATUS, {20'h0, rnd[3:0], 8'h2F}, 32'hF2F);
			rd(`DTD_ADR_SHIFT, {28'h0, rnd[3:0]}, '1);
			push("serial", {28'h0, rnd[3:0]}, '1);
			push("serial", {28'h0, rnd[3:0]}, '1);
			u_mpu.read_word();
			u_mpu.read_word();
		end
		// two keys in a row line; then two by two
		key(4'h2, 4'h5);
		rd(`DTD_ADR_STATUS, 32'h6, 32'hF);
		key(4'h3, 4'h5);
		rd(`DTD_ADR_STATUS, 32'h0, 32'hF);
		// peak and normal interval lengths of the lowest tones
		key(4'h1, 4'h1);
		push("row_alt", 32'h6E0, '1);
		push("row_norm", 32'h708, '1);
		push("col_alt", 32'h3E8, '1);
		push("col_norm", 32'h410, '1);
		-> meas_go;
		@(meas_done);
		key(4'h0, 4'h0);
		// digit written in, held back until inhibit drops
		rnd = lfsr(rnd);
		wb(1'b1, `DTD_ADR_CTRL, 4'hF, 32'h3);
		u_mpu.write_word(rnd[3:0]);
		rd(`DTD_ADR_STATUS, 32'h10, 32'h12);
		rd(`DTD_ADR_SHIFT, {28'h0, rnd[3:0]}, '1);
		wb(1'b1, `DTD_ADR_CTRL, 4'hF, 32'h1);
		repeat (4) @(posedge clk);
		rd(`DTD_ADR_STATUS, {20'h0, rnd[3:0], 8'h1E}, 32'hF1E);
		give_verdict();
	end
endmodule
